// >>> src/pcc_pkg.sv
// Constants, register map and carrier types of the position compare and capture block
// How it works
// - Eight independent limit-switch channels, each configured separately, one status bit each.
// - Each channel picks motor feedback, motor command, master feedback or free time.
// - Except rotary with on above off, status is on only while on point < value < off point.
// - Moving negative, status comes on past the off point, goes off at the on point.
// - Direction setting allows both, positive only or negative only travel.
// - Rotary off: compare uses the raw source value, no wrapping.
// - Rotary on: source is reduced into zero up to the rollover point.
// - Rotary with on above off: active outside interval, only after on reached.
// - From zero up to eight independent capture units.
// - A capture latches a free-running 32-bit microsecond counter.
// - A capture also latches command, feedback and master positions.
// - Done flag sets on strobe rising edge only when armed, not re-armed that cycle and not already done.
// - Done flag holds until re-arm or arm removal; re-arm allows another capture.
// - While done, further strobe edges are ignored and data stays put.
// - Dropping arm clears the done flag but keeps latched data.
// - While not armed the strobe does nothing.
// - Latched data stays until re-armed and a new qualifying edge overwrites it.
package pcc_pkg;
    localparam int PCC_MAX_SWITCH = 8;
    localparam int PCC_MAX_GRAB = 8;
    localparam int PCC_ADDR_W = 12;

    // Free time counter tick
    localparam int PCC_TICK_NS = 1000;
    localparam int PCC_CLK_PERIOD_NS = 5;
    localparam int PCC_CYC_PER_TICK = PCC_TICK_NS / PCC_CLK_PERIOD_NS;
    localparam logic [7:0] PCC_PRESCALE_LAST = 8'(PCC_CYC_PER_TICK - 1);

    // Register map
    localparam logic [11:0] PCC_REG_SWITCH_STATUS = 12'h000;
    localparam logic [11:0] PCC_REG_GRAB_DONE = 12'h004;
    localparam logic [11:0] PCC_REG_IRQ_STATUS = 12'h008;
    localparam logic [11:0] PCC_REG_IRQ_CLEAR = 12'h00c;
    localparam logic [11:0] PCC_REG_IRQ_ENABLE = 12'h010;
    localparam logic [11:0] PCC_REG_FREE_TIME = 12'h014;
    localparam logic [3:0] PCC_REGION_SWITCH = 4'h1;
    localparam logic [3:0] PCC_REGION_GRAB = 4'h2;
    localparam logic [1:0] PCC_SW_CFG = 2'h0;
    localparam logic [1:0] PCC_SW_ON = 2'h1;
    localparam logic [1:0] PCC_SW_OFF = 2'h2;
    localparam logic [1:0] PCC_SW_ROLL = 2'h3;
    localparam logic [1:0] PCC_GR_TIME = 2'h0;
    localparam logic [1:0] PCC_GR_CMD = 2'h1;
    localparam logic [1:0] PCC_GR_FB = 2'h2;
    localparam logic [1:0] PCC_GR_MASTER = 2'h3;

    // Config word fields and switch bit offset in the interrupt registers
    localparam int PCC_CFG_SRC_LSB = 0;
    localparam int PCC_CFG_DIR_LSB = 2;
    localparam int PCC_CFG_ROT_BIT = 4;
    localparam int PCC_IRQ_SWITCH_LSB = 8;

    typedef logic signed [31:0] pcc_word_t;

    typedef enum logic [1:0] {
        PCC_SRC_MOTOR_FB = 2'h0,
        PCC_SRC_MOTOR_CMD = 2'h1,
        PCC_SRC_MASTER_FB = 2'h2,
        PCC_SRC_FREE_TIME = 2'h3
    } pcc_src_t;

    typedef enum logic [1:0] {
        PCC_DIR_BOTH = 2'h0,
        PCC_DIR_PLUS = 2'h1,
        PCC_DIR_MINUS = 2'h2
    } pcc_dir_t;

    typedef struct packed {
        pcc_word_t motorFeedbackPos;
        pcc_word_t motorCommandPos;
        pcc_word_t masterFeedbackPos;
    } pcc_pos_t;

    typedef struct packed {
        logic rotary;
        logic [1:0] dir;
        logic [1:0] src;
        pcc_word_t onPoint;
        pcc_word_t offPoint;
        pcc_word_t rolloverPoint;
    } pcc_switch_cfg_t;

    typedef struct packed {
        logic [31:0] latchedTimestamp;
        pcc_word_t latchedCommandPos;
        pcc_word_t latchedFeedbackPos;
        pcc_word_t latchedMasterPos;
    } pcc_grab_t;

    localparam pcc_switch_cfg_t PCC_CFG_RESET = '0;
    localparam pcc_grab_t PCC_GRAB_RESET = '0;
endpackage : pcc_pkg

// >>> src/pcc_position_compare_capture.sv
// Limit-switch compare bank and capture units with register port and interrupt
`timescale 1ns/10ps
module pcc_position_compare_capture
    import pcc_pkg::*;
#(
    parameter int NUM_GRAB = PCC_MAX_GRAB
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire pcc_pos_t positions,
    input wire logic [PCC_MAX_GRAB-1:0] grabArm,
    input wire logic [PCC_MAX_GRAB-1:0] grabStrobe,
    input wire logic [PCC_MAX_GRAB-1:0] grabRearm,
    input wire logic [PCC_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    output logic [PCC_MAX_SWITCH-1:0] switchStatus,
    output logic [PCC_MAX_GRAB-1:0] grabDoneFlag,
    output logic irq
);
    typedef struct packed {
        pcc_switch_cfg_t [PCC_MAX_SWITCH-1:0] cfg;
        pcc_word_t [PCC_MAX_SWITCH-1:0] wrapped;
        pcc_word_t [PCC_MAX_SWITCH-1:0] prevSrc;
        logic [PCC_MAX_SWITCH-1:0] movingNeg;
        logic [PCC_MAX_SWITCH-1:0] seenOn;
        logic [PCC_MAX_SWITCH-1:0] status;
        pcc_grab_t [PCC_MAX_GRAB-1:0] grab;
        logic [PCC_MAX_GRAB-1:0] done;
        logic [PCC_MAX_GRAB-1:0] strobePrev;
        logic [15:0] irqStatus;
        logic [15:0] irqEnable;
        logic [31:0] freeTime;
        logic [7:0] prescale;
        logic [31:0] rdData;
    } pcc_state_t;

    pcc_state_t state_q;
    pcc_state_t state_d;

    pcc_word_t curSrc [PCC_MAX_SWITCH];
    pcc_word_t cmpVal [PCC_MAX_SWITCH];
    pcc_word_t wrapSum [PCC_MAX_SWITCH];
    logic dirOk [PCC_MAX_SWITCH];
    logic rotaryOn [PCC_MAX_SWITCH];
    logic inverted [PCC_MAX_SWITCH];
    logic [PCC_MAX_GRAB-1:0] strobeEdge;
    logic [PCC_MAX_GRAB-1:0] grabUsed;
    logic [15:0] events;
    logic [2:0] regIdx;
    logic [1:0] regField;

    if (NUM_GRAB < 0 || NUM_GRAB > PCC_MAX_GRAB)
    begin : gBadGrabCount
        $error("NUM_GRAB must lie between zero and eight");
    end

    function automatic pcc_word_t pcc_pick(input logic [1:0] sel, input pcc_pos_t p,
                                            input logic [31:0] t);
        case (sel)
            PCC_SRC_MOTOR_FB: pcc_pick = p.motorFeedbackPos;
            PCC_SRC_MOTOR_CMD: pcc_pick = p.motorCommandPos;
            PCC_SRC_MASTER_FB: pcc_pick = p.masterFeedbackPos;
            default: pcc_pick = pcc_word_t'(t);
        endcase
    endfunction : pcc_pick

    always_comb
    begin
        state_d = state_q;
        events = '0;
        regIdx = regAddr[6:4];
        regField = regAddr[3:2];
        for (int i = 0; i < PCC_MAX_GRAB; i++)
        begin
            grabUsed[i] = (i < NUM_GRAB);
        end
        strobeEdge = grabStrobe & ~state_q.strobePrev & grabUsed;

        // Microsecond free time counter
        if (state_q.prescale == PCC_PRESCALE_LAST)
        begin
            state_d.prescale = '0;
            state_d.freeTime = state_q.freeTime + 32'h00000001;
        end
        else
        begin
            state_d.prescale = state_q.prescale + 8'h01;
        end

        // Limit-switch channels
        for (int ch = 0; ch < PCC_MAX_SWITCH; ch++)
        begin
            curSrc[ch] = pcc_pick(state_q.cfg[ch].src, positions, state_q.freeTime);
            wrapSum[ch] = state_q.wrapped[ch] + (curSrc[ch] - state_q.prevSrc[ch]);
            // One correction per cycle; a large jump settles over several cycles
            if ($signed(state_q.cfg[ch].rolloverPoint) > 0)
            begin
                if ($signed(wrapSum[ch]) >= $signed(state_q.cfg[ch].rolloverPoint))
                begin
                    wrapSum[ch] = wrapSum[ch] - state_q.cfg[ch].rolloverPoint;
                end
                else if ($signed(wrapSum[ch]) < 0)
                begin
                    wrapSum[ch] = wrapSum[ch] + state_q.cfg[ch].rolloverPoint;
                end
            end
            else
            begin
                wrapSum[ch] = curSrc[ch];
            end
            state_d.wrapped[ch] = wrapSum[ch];
            state_d.prevSrc[ch] = curSrc[ch];
            if ($signed(curSrc[ch]) > $signed(state_q.prevSrc[ch]))
            begin
                state_d.movingNeg[ch] = 1'b0;
            end
            else if ($signed(curSrc[ch]) < $signed(state_q.prevSrc[ch]))
            begin
                state_d.movingNeg[ch] = 1'b1;
            end
            rotaryOn[ch] = state_q.cfg[ch].rotary && ($signed(state_q.cfg[ch].rolloverPoint) > 0);
            cmpVal[ch] = rotaryOn[ch] ? wrapSum[ch] : curSrc[ch];
            case (state_q.cfg[ch].dir)
                PCC_DIR_PLUS: dirOk[ch] = !state_d.movingNeg[ch];
                PCC_DIR_MINUS: dirOk[ch] = state_d.movingNeg[ch];
                default: dirOk[ch] = 1'b1;
            endcase
            if ($signed(cmpVal[ch]) >= $signed(state_q.cfg[ch].onPoint))
            begin
                state_d.seenOn[ch] = 1'b1;
            end
            inverted[ch] = rotaryOn[ch] &&
                ($signed(state_q.cfg[ch].onPoint) > $signed(state_q.cfg[ch].offPoint));
            if (inverted[ch])
            begin
                state_d.status[ch] = dirOk[ch] && state_d.seenOn[ch] &&
                    (($signed(cmpVal[ch]) > $signed(state_q.cfg[ch].onPoint)) ||
                     ($signed(cmpVal[ch]) < $signed(state_q.cfg[ch].offPoint)));
            end
            else
            begin
                // Symmetric window also gives the negative-travel behaviour
                state_d.status[ch] = dirOk[ch] &&
                    ($signed(cmpVal[ch]) > $signed(state_q.cfg[ch].onPoint)) &&
                    ($signed(cmpVal[ch]) < $signed(state_q.cfg[ch].offPoint));
            end
        end

        // Capture units
        for (int u = 0; u < PCC_MAX_GRAB; u++)
        begin
            state_d.strobePrev[u] = grabStrobe[u] & grabUsed[u];
            if (!grabUsed[u] || !grabArm[u])
            begin
                state_d.done[u] = 1'b0;
            end
            else if (grabRearm[u])
            begin
                state_d.done[u] = 1'b0;
            end
            else if (strobeEdge[u] && !state_q.done[u])
            begin
                state_d.done[u] = 1'b1;
                state_d.grab[u].latchedTimestamp = state_q.freeTime;
                state_d.grab[u].latchedCommandPos = positions.motorCommandPos;
                state_d.grab[u].latchedFeedbackPos = positions.motorFeedbackPos;
                state_d.grab[u].latchedMasterPos = positions.masterFeedbackPos;
            end
        end

        // Sticky interrupt status: a new event beats a clear in the same cycle
        events[PCC_MAX_GRAB-1:0] = state_d.done & ~state_q.done;
        events[PCC_IRQ_SWITCH_LSB +: PCC_MAX_SWITCH] = state_d.status & ~state_q.status;
        state_d.irqStatus = state_q.irqStatus;
        if (regWrEn && regAddr == PCC_REG_IRQ_CLEAR)
        begin
            state_d.irqStatus = state_q.irqStatus & ~regWrData[15:0];
        end
        state_d.irqStatus = state_d.irqStatus | events;

        // Register writes
        if (regWrEn)
        begin
            if (regAddr == PCC_REG_IRQ_ENABLE)
            begin
                state_d.irqEnable = regWrData[15:0];
            end
            else if (regAddr[11:8] == PCC_REGION_SWITCH && regAddr[7] == 1'b0)
            begin
                state_d.seenOn[regIdx] = 1'b0;
                case (regField)
                    PCC_SW_CFG:
                    begin
                        state_d.cfg[regIdx].src = regWrData[PCC_CFG_SRC_LSB +: 2];
                        state_d.cfg[regIdx].dir = regWrData[PCC_CFG_DIR_LSB +: 2];
                        state_d.cfg[regIdx].rotary = regWrData[PCC_CFG_ROT_BIT];
                    end
                    PCC_SW_ON: state_d.cfg[regIdx].onPoint = regWrData;
                    PCC_SW_OFF: state_d.cfg[regIdx].offPoint = regWrData;
                    default: state_d.cfg[regIdx].rolloverPoint = regWrData;
                endcase
            end
        end

        // Register reads, data valid in the following cycle only
        state_d.rdData = '0;
        if (regRdEn)
        begin
            if (regAddr == PCC_REG_SWITCH_STATUS)
            begin
                state_d.rdData = {24'h000000, state_q.status};
            end
            else if (regAddr == PCC_REG_GRAB_DONE)
            begin
                state_d.rdData = {24'h000000, state_q.done};
            end
            else if (regAddr == PCC_REG_IRQ_STATUS)
            begin
                state_d.rdData = {16'h0000, state_q.irqStatus};
            end
            else if (regAddr == PCC_REG_IRQ_ENABLE)
            begin
                state_d.rdData = {16'h0000, state_q.irqEnable};
            end
            else if (regAddr == PCC_REG_FREE_TIME)
            begin
                state_d.rdData = state_q.freeTime;
            end
            else if (regAddr[11:8] == PCC_REGION_SWITCH && regAddr[7] == 1'b0)
            begin
                case (regField)
                    PCC_SW_CFG: state_d.rdData = {27'h0000000, state_q.cfg[regIdx].rotary,
                        state_q.cfg[regIdx].dir, state_q.cfg[regIdx].src};
                    PCC_SW_ON: state_d.rdData = state_q.cfg[regIdx].onPoint;
                    PCC_SW_OFF: state_d.rdData = state_q.cfg[regIdx].offPoint;
                    default: state_d.rdData = state_q.cfg[regIdx].rolloverPoint;
                endcase
            end
            else if (regAddr[11:8] == PCC_REGION_GRAB && regAddr[7] == 1'b0 && grabUsed[regIdx])
            begin
                case (regField)
                    PCC_GR_TIME: state_d.rdData = state_q.grab[regIdx].latchedTimestamp;
                    PCC_GR_CMD: state_d.rdData = state_q.grab[regIdx].latchedCommandPos;
                    PCC_GR_FB: state_d.rdData = state_q.grab[regIdx].latchedFeedbackPos;
                    default: state_d.rdData = state_q.grab[regIdx].latchedMasterPos;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign regRdData = state_q.rdData;
    assign switchStatus = state_q.status;
    assign grabDoneFlag = state_q.done;
    assign irq = |(state_q.irqStatus & state_q.irqEnable);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    freeTimeTick_a: assert property (
        state_q.prescale == PCC_PRESCALE_LAST |=> state_q.freeTime == $past(state_q.freeTime) + 1)
        else $error("free time counter did not advance on its tick");

    freeTimeHold_a: assert property (
        state_q.prescale != PCC_PRESCALE_LAST |=> $stable(state_q.freeTime))
        else $error("free time counter moved between ticks");

    readIdle_a: assert property (
        !regRdEn |=> state_q.rdData == 32'h00000000)
        else $error("read data not zero outside a read");

    statusRead_a: assert property (
        regRdEn && regAddr == PCC_REG_SWITCH_STATUS |=>
            state_q.rdData == {24'h000000, $past(state_q.status)})
        else $error("switch status read returned wrong data");

    doneRead_a: assert property (
        regRdEn && regAddr == PCC_REG_GRAB_DONE |=>
            state_q.rdData == {24'h000000, $past(state_q.done)})
        else $error("done flag read returned wrong data");

    irqEnableWrite_a: assert property (
        regWrEn && regAddr == PCC_REG_IRQ_ENABLE |=> state_q.irqEnable == 16'($past(regWrData)))
        else $error("interrupt enable write did not land");

    for (genvar u = 0; u < PCC_MAX_GRAB; u++)
    begin : gGrabChecks
        if (u < NUM_GRAB)
        begin : gUsed
            sequence qualEdge;
                grabArm[u] && !grabRearm[u] && strobeEdge[u] && !state_q.done[u];
            endsequence
            sequence heldDone;
                grabArm[u] && !grabRearm[u] && state_q.done[u];
            endsequence

            grabCapture_a: assert property (
                qualEdge |=> state_q.done[u] &&
                    state_q.grab[u].latchedTimestamp == $past(state_q.freeTime) &&
                    state_q.grab[u].latchedFeedbackPos == $past(positions.motorFeedbackPos))
                else $error("qualifying strobe edge did not capture");

            grabIgnore_a: assert property (
                heldDone |=> state_q.done[u] && $stable(state_q.grab[u]))
                else $error("capture changed while done flag was held");

            grabDisarm_a: assert property (
                !grabArm[u] |=> !state_q.done[u] && $stable(state_q.grab[u]))
                else $error("disarm did not clear done or altered data");

            grabRearmWins_a: assert property (
                grabArm[u] && grabRearm[u] |=> !state_q.done[u] && $stable(state_q.grab[u]))
                else $error("re-arm did not win over a strobe edge");

            grabIrqSet_a: assert property (
                qualEdge ##1 state_q.done[u] |-> state_q.irqStatus[u])
                else $error("capture event did not set interrupt status");

            grabDataHold_a: assert property (
                !(grabArm[u] && !grabRearm[u] && strobeEdge[u] && !state_q.done[u]) |=>
                    $stable(state_q.grab[u]))
                else $error("latched data changed without a qualifying edge");
        end
        else
        begin : gUnused
            grabUnused_a: assert property (
                !state_q.done[u])
                else $error("capture unit beyond the configured count triggered");
        end
    end

    for (genvar ch = 0; ch < PCC_MAX_SWITCH; ch++)
    begin : gSwitchChecks
        switchWindow_a: assert property (
            !inverted[ch] && !($signed(cmpVal[ch]) > $signed(state_q.cfg[ch].onPoint) &&
                $signed(cmpVal[ch]) < $signed(state_q.cfg[ch].offPoint)) |=> !state_q.status[ch])
            else $error("switch active outside its window");

        switchRaw_a: assert property (
            !state_q.cfg[ch].rotary |-> cmpVal[ch] == curSrc[ch])
            else $error("non-rotary compare used a wrapped value");

        switchDir_a: assert property (
            state_q.cfg[ch].dir == PCC_DIR_PLUS && state_d.movingNeg[ch] |=> !state_q.status[ch])
            else $error("plus-only switch active while moving negative");

        switchMinus_a: assert property (
            state_q.cfg[ch].dir == PCC_DIR_MINUS && !state_d.movingNeg[ch] |=>
                !state_q.status[ch])
            else $error("minus-only switch active while moving positive");

        // A register write clears the memory only after this cycle's status is formed
        switchFirstOn_a: assert property (
            inverted[ch] && !state_q.seenOn[ch] &&
                $signed(cmpVal[ch]) < $signed(state_q.cfg[ch].onPoint) |=> !state_q.status[ch])
            else $error("inverted switch active before on point reached");

        switchIrqSet_a: assert property (
            !state_q.status[ch] ##1 state_q.status[ch] |->
                state_q.irqStatus[PCC_IRQ_SWITCH_LSB + ch])
            else $error("switch status rise did not set interrupt status");
    end
endmodule : pcc_position_compare_capture

// >>> tb/pcc_position_source.sv
// Model of the feedback, command and master position sources
`timescale 1ns/10ps
module pcc_position_source
    import pcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire pcc_pos_t target,
    output pcc_pos_t positions,
    output logic atTarget
);
    // Ramp one unit a clock so the direction of travel is always defined
    function automatic pcc_word_t stepTo(input pcc_word_t cur, input pcc_word_t tgt);
        if (tgt > cur)
            return cur + 32'sh1;
        if (tgt < cur)
            return cur - 32'sh1;
        return cur;
    endfunction : stepTo

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            positions <= '0;
        else
        begin
            positions.motorFeedbackPos <= stepTo(positions.motorFeedbackPos,
                target.motorFeedbackPos);
            positions.motorCommandPos <= stepTo(positions.motorCommandPos,
                target.motorCommandPos);
            positions.masterFeedbackPos <= stepTo(positions.masterFeedbackPos,
                target.masterFeedbackPos);
        end
    end

    assign atTarget = (positions === target);
endmodule : pcc_position_source

// >>> tb/pcc_position_compare_capture_tb.sv
// Self-checking testbench of the position compare and capture block
`timescale 1ns/10ps
module pcc_position_compare_capture_tb import pcc_pkg::*;;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    pcc_pos_t target = '0;
    pcc_pos_t positions;
    logic atTarget;
    logic [7:0] grabArm = 8'h00;
    logic [7:0] grabStrobe = 8'h00;
    logic [7:0] grabRearm = 8'h00;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWrData = 32'h0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [31:0] regRdData;
    logic [7:0] switchStatus;
    logic [7:0] grabDoneFlag;
    logic irq;
    logic [7:0] noGrabDone;
    logic [31:0] rd;
    logic [31:0] t0;
    int mismatches = 0;
    int comparisons = 0;

    pcc_position_source src_u (.clk(clk), .reset_n(reset_n), .target(target),
        .positions(positions), .atTarget(atTarget));

    pcc_position_compare_capture dut_u (.clk(clk), .reset_n(reset_n), .positions(positions),
        .grabArm(grabArm), .grabStrobe(grabStrobe), .grabRearm(grabRearm), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .switchStatus(switchStatus), .grabDoneFlag(grabDoneFlag), .irq(irq));

    // Built with no capture units: its done flags must never rise
    pcc_position_compare_capture #(.NUM_GRAB(0)) dut_none_u (.clk(clk), .reset_n(reset_n),
        .positions(positions), .grabArm(grabArm), .grabStrobe(grabStrobe),
        .grabRearm(grabRearm), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(), .switchStatus(), .grabDoneFlag(noGrabDone), .irq());

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic regWrite(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask : regRead

    // Positions: feedback v, command v+1000, master v+2000
    task automatic moveTo(input int v);
        @(posedge clk);
        target.motorFeedbackPos <= v;
        target.motorCommandPos <= v + 1000;
        target.masterFeedbackPos <= v + 2000;
        repeat (3000)
        begin
            @(posedge clk);
            #1;
            if (atTarget)
                break;
        end
        check({31'h0, atTarget}, 32'h1, "source ramp");
        repeat (4) @(posedge clk);
        #1;
    endtask : moveTo

    task automatic cfgSwitch(input int ch, input logic [4:0] cfg, input int on, input int off,
        input int roll);
        logic [11:0] base;
        base = 12'h100 + 12'(ch * 16);
        regWrite(base, {27'h0, cfg});
        regWrite(base + 12'h4, on);
        regWrite(base + 12'h8, off);
        regWrite(base + 12'hc, roll);
    endtask : cfgSwitch

    task automatic strobe(input logic withRearm);
        @(posedge clk);
        grabStrobe[0] <= 1'b1;
        grabRearm[0] <= withRearm;
        @(posedge clk);
        grabStrobe[0] <= 1'b0;
        grabRearm[0] <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : strobe

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        regRead(12'h004, rd);
        check(rd, 32'h0, "done flags after reset");
        regRead(12'h300, rd);
        check(rd, 32'h0, "unmapped read");
        regWrite(12'h010, 32'h1);
        regRead(12'h010, rd);
        check(rd, 32'h1, "irq enable readback");
        // Two reads a whole tick apart see the counter one step further
        regRead(12'h014, t0);
        repeat (PCC_CYC_PER_TICK - 2) @(posedge clk);
        regRead(12'h014, rd);
        check(rd - t0, 32'h1, "free time tick");
        $display("test registers done");

        // ch0 both, ch1 plus, ch2 command source, ch3 rotary, ch4 not rotary, ch5 minus,
        // ch6 rotary with on above off, ch7 master source
        cfgSwitch(0, 5'h00, 10, 20, 0);
        cfgSwitch(1, 5'h04, 10, 20, 0);
        cfgSwitch(2, 5'h01, 1010, 1020, 0);
        cfgSwitch(3, 5'h10, 90, 100, 360);
        cfgSwitch(4, 5'h00, 90, 100, 360);
        cfgSwitch(5, 5'h08, 10, 20, 0);
        cfgSwitch(6, 5'h10, 300, 100, 360);
        cfgSwitch(7, 5'h02, 2010, 2020, 0);
        moveTo(15);
        check({24'h0, switchStatus}, 32'h87, "inside window rising");
        moveTo(20);
        check({24'h0, switchStatus}, 32'h00, "at off point");
        moveTo(25);
        moveTo(19);
        check({24'h0, switchStatus}, 32'ha5, "inside window falling");
        moveTo(455);
        check({24'h0, switchStatus}, 32'h48, "rollover window");
        regRead(12'h000, rd);
        check(rd, 32'h48, "status register");
        cfgSwitch(4, 5'h03, 0, 1000000, 0);
        regRead(12'h000, rd);
        check(rd, 32'h58, "time source");
        $display("test limit switches done");

        @(posedge clk);
        grabArm[0] <= 1'b1;
        regRead(12'h014, t0);
        strobe(1'b0);
        check({31'h0, grabDoneFlag[0]}, 32'h1, "done after edge");
        check({24'h0, noGrabDone}, 32'h0, "unit beyond count");
        check({31'h0, irq}, 32'h1, "irq after capture");
        regRead(12'h200, rd);
        check({31'h0, (rd - t0) <= 32'h1}, 32'h1, "timestamp");
        regRead(12'h204, rd);
        check(rd, 32'd1455, "latched command");
        regRead(12'h208, rd);
        check(rd, 32'd455, "latched feedback");
        regRead(12'h20c, rd);
        check(rd, 32'd2455, "latched master");
        moveTo(500);
        strobe(1'b0);
        regRead(12'h208, rd);
        check(rd, 32'd455, "edge while done");
        check({31'h0, grabDoneFlag[0]}, 32'h1, "done holds");
        regWrite(12'h00c, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0, "irq cleared");
        strobe(1'b1);
        check({31'h0, grabDoneFlag[0]}, 32'h0, "rearm with edge");
        regRead(12'h208, rd);
        check(rd, 32'd455, "no capture with rearm");
        strobe(1'b0);
        regRead(12'h208, rd);
        check(rd, 32'd500, "new capture");
        @(posedge clk);
        grabArm[0] <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, grabDoneFlag[0]}, 32'h0, "disarm clears done");
        moveTo(600);
        strobe(1'b0);
        check({31'h0, grabDoneFlag[0]}, 32'h0, "edge while disarmed");
        regRead(12'h208, rd);
        check(rd, 32'd500, "data kept");
        $display("test capture done");
        final_report();
    end
endmodule : pcc_position_compare_capture_tb
